/* src/ahs_adc_serial.sv */
`timescale 1ns/1ns
// Contract
// RL1 - Host clocks transfers in eight-pulse bursts
// RL2 - Host fetches result promptly on ready interrupt
// RL3 - Without interrupt, host sets filter sync hold
// RL4 - Shared data wire: drive, then release, alternately
// RL5 - Clock idles high; change falling, sample rising
// RL6 - Read command 0x78 returns high, middle, low
// RL7 - Command byte plus value byte writes configuration
// RL8 - Chip select tied low; framing by counting
// RL9 - Software write: bit seven first, shift left
// RL10 - Software read: sample after falling, MSB first
// RL11 - Ready pin low when new result readable
// RL12 - Host assembles bytes into 24-bit word
module ahs_adc_serial (
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic        sclk,
    input  wire logic        din,
    output logic             dout_o,
    output logic             dout_oe_n,
    output logic             result_ready_n,
    input  wire logic [23:0] res_data,
    input  wire logic        res_valid,
    output logic             res_ready,
    output logic [7:0]       global_setup_one_value,
    output logic [7:0]       global_setup_two_value,
    output logic [7:0]       global_setup_three_value,
    output logic [7:0]       transfer_function_one_value,
    output logic [7:0]       transfer_function_two_value,
    output logic [7:0]       transfer_function_three_value,
    output logic             filter_sync_hold
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    ahs_pkg::ahs_link_st_t st_q;
    ahs_pkg::ahs_link_st_t st_d;
    logic        link_rst_n;
    logic [2:0]  bit_q;
    logic [6:0]  sh_q;
    logic [7:0]  byte_in;
    logic        byte_end;
    logic        is_wr_cmd;
    logic        cmd_fire;
    logic        wval_fire;
    logic        rd_last;
    logic        rd_active;
    logic        rd_next;
    logic [1:0]  rd_byte;
    logic [4:0]  rd_pos;
    logic [2:0]  sel_q;
    logic [7:0]  val_q;
    logic        wr_tgl_q;
    logic        rd_tgl_q;
    logic        rd_busy_q;
    logic        dout_q;
    logic        oe_n_q;

    logic [2:0]  link_sync;
    logic [1:0]  tgl_prev_q;
    logic        wr_ev;
    logic        rd_ev;
    logic        busy_s;
    logic        load_ok;
    logic        load;
    logic        pending_q;
    logic [23:0] data_q;
    logic [7:0]  cfg_q [ahs_pkg::CFG_REGS];

    // ----------------------------------------------------------------
    // Result buffer
    // ----------------------------------------------------------------
    ahs_stream_if #(.W(ahs_pkg::RESULT_W)) in_s ();
    ahs_stream_if #(.W(ahs_pkg::RESULT_W)) out_s ();

    assign in_s.valid = res_valid;
    assign in_s.data  = res_data;
    assign res_ready  = in_s.ready;

    ahs_fifo2 #(
        .W     (ahs_pkg::RESULT_W),
        .DEPTH (ahs_pkg::BUF_DEPTH)
    ) u_buf (
        .clock (clock),
        .nrst  (nrst),
        .in_s  (in_s.snk),
        .out_s (out_s.src)
    );

    // ----------------------------------------------------------------
    // Link side, clocked by the serial clock
    // ----------------------------------------------------------------
    // The link needs serial clock edges while reset is low to see it
    ahs_sync2 #(.W(1)) u_link_rst (
        .clock (sclk),
        .rst_n (1'b1),
        .d     (nrst),
        .q     (link_rst_n)
    );

    assign byte_in   = {sh_q, din};
    assign byte_end  = (bit_q == ahs_pkg::LAST_BIT);
    assign is_wr_cmd = (byte_in[3:0] == ahs_pkg::CMD_WR_LOW)
                    && (byte_in[7:4] >= ahs_pkg::CMD_WR_FIRST)
                    && (byte_in[7:4] <= ahs_pkg::CMD_WR_LAST);
    assign cmd_fire  = (st_q == ahs_pkg::LS_CMD) && byte_end && is_wr_cmd;
    assign wval_fire = (st_q == ahs_pkg::LS_WVAL) && byte_end;
    assign rd_last   = (st_q == ahs_pkg::LS_RD_L) && byte_end;
    assign rd_active = (st_q == ahs_pkg::LS_RD_H) || (st_q == ahs_pkg::LS_RD_M)
                    || (st_q == ahs_pkg::LS_RD_L);
    assign rd_next   = (st_d == ahs_pkg::LS_RD_H) || (st_d == ahs_pkg::LS_RD_M)
                    || (st_d == ahs_pkg::LS_RD_L);
    assign rd_byte   = (st_q == ahs_pkg::LS_RD_H) ? 2'h0
                     : (st_q == ahs_pkg::LS_RD_M) ? 2'h1 : 2'h2;
    assign rd_pos    = ahs_pkg::RESULT_MSB - {rd_byte, bit_q};

    // Byte framing purely by counting, there is no select to realign
    always_comb begin
        st_d = st_q;
        if (byte_end) begin
            case (st_q)
                ahs_pkg::LS_CMD: begin
                    if (byte_in == ahs_pkg::CMD_READ) begin
                        st_d = ahs_pkg::LS_RD_H; // RL6
                    end else if (is_wr_cmd) begin
                        st_d = ahs_pkg::LS_WVAL; // RL7
                    end
                end
                ahs_pkg::LS_WVAL: st_d = ahs_pkg::LS_CMD;
                ahs_pkg::LS_RD_H: st_d = ahs_pkg::LS_RD_M;
                ahs_pkg::LS_RD_M: st_d = ahs_pkg::LS_RD_L;
                default:          st_d = ahs_pkg::LS_CMD;
            endcase
        end
    end

    // Input bits sampled on the rising edge
    always_ff @(posedge sclk) begin
        if (!link_rst_n) begin
            st_q      <= ahs_pkg::LS_CMD;
            bit_q     <= 3'h0;
            sh_q      <= 7'h00;
            rd_busy_q <= 1'b0;
        end else begin
            st_q      <= st_d;
            bit_q     <= bit_q + 3'h1; // RL1 RL8
            sh_q      <= byte_in[6:0]; // RL5
            rd_busy_q <= rd_next;
        end
    end

    // Held words stay put until the next command pair, long after the core took them
    always_ff @(posedge sclk) begin
        if (!link_rst_n) begin
            sel_q    <= 3'h0;
            val_q    <= 8'h00;
            wr_tgl_q <= 1'b0;
            rd_tgl_q <= 1'b0;
        end else begin
            if (cmd_fire) begin
                sel_q <= byte_in[6:4] - 3'h1; // RL7
            end
            if (wval_fire) begin
                val_q    <= byte_in;
                wr_tgl_q <= ~wr_tgl_q; // RL7
            end
            if (rd_last) begin
                rd_tgl_q <= ~rd_tgl_q;
            end
        end
    end

    // Output bits change on the falling edge; data_q is frozen by the pending flag
    always_ff @(negedge sclk) begin
        if (!link_rst_n) begin
            dout_q <= 1'b1;
            oe_n_q <= 1'b1;
        end else begin
            oe_n_q <= !rd_active; // RL4
            dout_q <= rd_active ? data_q[rd_pos] : 1'b1; // RL6
        end
    end

    assign dout_o    = dout_q;
    assign dout_oe_n = oe_n_q;

    // ----------------------------------------------------------------
    // Core side
    // ----------------------------------------------------------------
    ahs_sync2 #(.W(3)) u_core_sync (
        .clock (clock),
        .rst_n (nrst),
        .d     ({rd_busy_q, rd_tgl_q, wr_tgl_q}),
        .q     (link_sync)
    );

    assign wr_ev   = link_sync[0] ^ tgl_prev_q[0];
    assign rd_ev   = link_sync[1] ^ tgl_prev_q[1];
    assign busy_s  = link_sync[2];
    // No reload during a read or while the host holds the filter
    assign load_ok = !pending_q && !busy_s && !filter_sync_hold; // RL3
    assign load    = out_s.valid && load_ok;
    assign out_s.ready = load_ok;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            tgl_prev_q <= 2'h0;
            pending_q  <= 1'b0;
            data_q     <= 24'h000000;
        end else begin
            tgl_prev_q <= link_sync[1:0];
            if (load) begin
                data_q    <= out_s.data;
                pending_q <= 1'b1; // RL11
            end else if (rd_ev) begin
                pending_q <= 1'b0;
            end
        end
    end

    assign result_ready_n = !pending_q; // RL11

    genvar gi;
    for (gi = 0; gi < ahs_pkg::CFG_REGS; gi++) begin : g_cfg
        always_ff @(posedge clock) begin
            if (!nrst) begin
                cfg_q[gi] <= ahs_pkg::CFG_RESET;
            end else if (wr_ev && (sel_q == 3'(gi))) begin
                cfg_q[gi] <= val_q; // RL7
            end
        end
    end

    assign global_setup_one_value        = cfg_q[0];
    assign global_setup_two_value        = cfg_q[1];
    assign global_setup_three_value      = cfg_q[2];
    assign transfer_function_one_value   = cfg_q[3];
    assign transfer_function_two_value   = cfg_q[4];
    assign transfer_function_three_value = cfg_q[5];
    assign filter_sync_hold = cfg_q[ahs_pkg::HOLD_REG][ahs_pkg::HOLD_BIT]; // RL3

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_read_cmd;
        st_q == ahs_pkg::LS_CMD && byte_end && byte_in == ahs_pkg::CMD_READ;
    endsequence

    sequence s_high_byte;
        (st_q == ahs_pkg::LS_RD_H)[*8] ##1 (st_q == ahs_pkg::LS_RD_M);
    endsequence

    chk_read_byte_order: assert property (@(posedge sclk) disable iff (!link_rst_n) // RL6
        s_read_cmd |=> s_high_byte)
        else $error("read command did not give an eight-bit high byte phase");

    chk_msb_first_out: assert property (@(posedge sclk) disable iff (!link_rst_n) // RL6
        rd_active |-> (!dout_oe_n && dout_o == data_q[rd_pos]))
        else $error("result bit on the line does not match its position");

    chk_release_line: assert property (@(posedge sclk) disable iff (!link_rst_n) // RL4
        (st_q == ahs_pkg::LS_CMD && bit_q != 3'h0) |-> dout_oe_n)
        else $error("data line driven outside a read");

    // Start only from an edge that already saw the link out of reset, since
    // the edge that releases it still holds the counter at zero
    chk_burst_count: assert property (@(posedge sclk) disable iff (!link_rst_n) // RL1
        link_rst_n |=> (bit_q == $past(bit_q) + 3'h1))
        else $error("bit counter broke the eight-pulse burst");

    chk_write_pair: assert property (@(posedge sclk) disable iff (!link_rst_n) // RL7
        wval_fire |=> (wr_tgl_q != $past(wr_tgl_q) && st_q == ahs_pkg::LS_CMD
                       && val_q == $past(byte_in)))
        else $error("value byte did not post a configuration write");

    sequence s_last_read_bit;
        st_q == ahs_pkg::LS_RD_L && byte_end;
    endsequence

    // Host may drive the joined wire again from its next falling edge
    chk_line_released: assert property (@(posedge sclk) disable iff (!link_rst_n) // RL4
        s_last_read_bit |=> dout_oe_n)
        else $error("data line still driven after the last read bit");

    // ----------------------------------------------------------------
    // Core side checks
    // ----------------------------------------------------------------

    chk_ready_after_load: assert property (@(posedge clock) disable iff (!nrst) // RL11
        load |=> (!result_ready_n && data_q == $past(out_s.data)))
        else $error("ready pin not low after a new result");

    chk_ready_holds: assert property (@(posedge clock) disable iff (!nrst) // RL11
        (!result_ready_n && !rd_ev) |=> (!result_ready_n && $stable(data_q)))
        else $error("ready or result changed before the read finished");

    chk_cfg_write_lands: assert property (@(posedge clock) disable iff (!nrst) // RL7
        (wr_ev && sel_q == 3'h0) |=> (global_setup_one_value == $past(val_q)))
        else $error("global setup one not written by its command");

    chk_ready_clears: assert property (@(posedge clock) disable iff (!nrst) // RL11
        (rd_ev && !result_ready_n) |=> result_ready_n)
        else $error("ready pin stayed low after the result was read");

    chk_hold_blocks_load: assert property (@(posedge clock) disable iff (!nrst) // RL3
        (filter_sync_hold && result_ready_n) |=> result_ready_n)
        else $error("new result offered while the filter hold was set");

endmodule

/* src/ahs_pkg.sv */
// ----------------------------------------------------------------
// Serial port constants
// ----------------------------------------------------------------
package ahs_pkg;

    // Command bytes seen on the serial input
    localparam logic [7:0] CMD_READ     = 8'h78;
    localparam logic [3:0] CMD_WR_FIRST = 4'h1;
    localparam logic [3:0] CMD_WR_LAST  = 4'h6;
    localparam logic [3:0] CMD_WR_LOW   = 4'h0;

    // Configuration store: three global setup, three transfer-function
    localparam int         CFG_REGS  = 6;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam int         HOLD_REG  = 1;
    localparam int         HOLD_BIT  = 0;

    // Framing and result layout
    localparam logic [2:0] LAST_BIT   = 3'h7;
    localparam int         RESULT_W   = 24;
    localparam logic [4:0] RESULT_MSB = 5'h17;
    localparam int         BUF_DEPTH  = 2;

    typedef enum logic [2:0] {
        LS_CMD,
        LS_WVAL,
        LS_RD_H,
        LS_RD_M,
        LS_RD_L
    } ahs_link_st_t;

endpackage

/* src/ahs_stream_if.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Valid/ready word carrier
// ----------------------------------------------------------------
interface ahs_stream_if #(
    parameter int W = 24
);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

/* src/ahs_sync2.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Two-stage synchroniser; only the second stage is visible
// ----------------------------------------------------------------
module ahs_sync2 #(
    parameter int W = 1
) (
    input  wire logic         clock,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule

/* src/ahs_fifo2.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Small result buffer with back-pressure
// ----------------------------------------------------------------
module ahs_fifo2 #(
    parameter int W     = 24,
    parameter int DEPTH = 2
) (
    input  wire logic clock,
    input  wire logic nrst,
    ahs_stream_if.snk in_s,
    ahs_stream_if.src out_s
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
    localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

    logic [W-1:0]  mem_q [DEPTH];
    logic [PW-1:0] wr_ptr_q;
    logic [PW-1:0] rd_ptr_q;
    logic [CW-1:0] count_q;
    logic          push;
    logic          pop;

    assign in_s.ready  = (count_q != CNT_FULL);
    assign out_s.valid = (count_q != '0);
    assign out_s.data  = mem_q[rd_ptr_q];
    assign push        = in_s.valid && in_s.ready;
    assign pop         = out_s.valid && out_s.ready;

    always_ff @(posedge clock) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_s.data;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == PTR_LAST) ? '0 : wr_ptr_q + PW'(1);
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == PTR_LAST) ? '0 : rd_ptr_q + PW'(1);
            end
            count_q <= count_q + CW'(push) - CW'(pop);
        end
    end

    chk_fifo_count_bound: assert property (@(posedge clock) disable iff (!nrst)
        (count_q == CNT_FULL && !pop) |=> (count_q == CNT_FULL && !in_s.ready))
        else $error("buffer lost its full state without a pop");
endmodule

/* testbench/ahs_host_model.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Host serial master: clock idles high, change on fall, sample on rise
// ----------------------------------------------------------------
module ahs_host_model (
    output logic      sclk,
    output logic      host_bit,
    output logic      host_oe,
    input  wire logic sdata
);
    initial begin
        sclk     = 1'b1;
        host_bit = 1'b1;
        host_oe  = 1'b0;
    end

    // Only used around reset, where the link logic is still held
    task automatic pulses(input int n);
        repeat (n) begin
            #3 sclk = 1'b0;
            #3 sclk = 1'b1;
        end
    endtask

    // One burst; with drive low the wire is left to the device
    task automatic xfer(input logic [7:0] tx, input logic drive, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 0; i < 8; i++) begin
            #3;
            host_oe  = drive;
            host_bit = tx[7];
            sclk     = 1'b0;
            tx       = {tx[6:0], 1'b0};
            #3;
            sclk     = 1'b1;
            rx       = {rx[6:0], sdata};
        end
        #3;
    endtask
endmodule

/* testbench/test_adc_serial_host_access.sv */
`timescale 1ns/1ns
module test_adc_serial_host_access;
    logic        clock;
    logic        nrst;
    logic        sclk;
    logic        host_bit;
    logic        host_oe;
    logic        dout_o;
    logic        dout_oe_n;
    logic        result_ready_n;
    logic [23:0] res_data;
    logic        res_valid;
    logic        res_ready;
    logic [7:0]  cfg_out [6];
    logic        filter_sync_hold;
    logic [7:0]  b;
    logic [31:0] seed;
    wire logic   sdata;
    int          num_errors;
    int          num_checks;
    int          cfg_m [6];
    logic [23:0] exp_q [$];

    // Pull-up on the joined wire; the device wins while it drives
    assign sdata = !dout_oe_n ? dout_o : (host_oe ? host_bit : 1'b1);

    initial clock = 1'b0;
    always #5 clock = ~clock;

    ahs_adc_serial dut_u (
        .clock                         (clock),
        .nrst                          (nrst),
        .sclk                          (sclk),
        .din                           (sdata),
        .dout_o                        (dout_o),
        .dout_oe_n                     (dout_oe_n),
        .result_ready_n                (result_ready_n),
        .res_data                      (res_data),
        .res_valid                     (res_valid),
        .res_ready                     (res_ready),
        .global_setup_one_value        (cfg_out[0]),
        .global_setup_two_value        (cfg_out[1]),
        .global_setup_three_value      (cfg_out[2]),
        .transfer_function_one_value   (cfg_out[3]),
        .transfer_function_two_value   (cfg_out[4]),
        .transfer_function_three_value (cfg_out[5]),
        .filter_sync_hold              (filter_sync_hold)
    );

    ahs_host_model host_u (
        .sclk     (sclk),
        .host_bit (host_bit),
        .host_oe  (host_oe),
        .sdata    (sdata)
    );

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic wr_cfg(input int idx, input logic [7:0] val);
        logic [7:0] rx;
        host_u.xfer(8'((idx + 1) * 16), 1'b1, rx);
        host_u.xfer(val, 1'b1, rx);
        cfg_m[idx] = val;
        #80;
    endtask

    task automatic check_cfg();
        @(negedge clock);
        for (int i = 0; i < 6; i++)
            chk("config", 24'(cfg_m[i]), {16'h0, cfg_out[i]});
        chk("filter_sync_hold", {23'h0, cfg_m[1][0]}, {23'h0, filter_sync_hold});
    endtask

    task automatic wait_rdy(input logic lvl);
        int n;
        n = 0;
        while (result_ready_n !== lvl && n < 60) begin
            @(negedge clock);
            n++;
        end
        chk("result_ready_n", {23'h0, lvl}, {23'h0, result_ready_n});
    endtask

    // Offer words every cycle; stop offering while the buffer refuses
    task automatic fill(input int tries, input logic want_full);
        int refused;
        refused = 0;
        for (int i = 0; i < tries; i++) begin
            @(negedge clock);
            seed = lfsr(seed);
            res_data = seed[23:0];
            res_valid = res_ready;
            if (res_ready === 1'b1)
                exp_q.push_back(seed[23:0]);
            else
                refused++;
        end
        @(negedge clock);
        res_valid = 1'b0;
        if (want_full)
            chk("res_ready refused", 24'h1, 24'(refused > 0));
    endtask

    // Host side: wait for the ready level, stall a while, fetch three bytes
    task automatic drain();
        logic [23:0] w;
        while (exp_q.size() > 0) begin
            wait_rdy(1'b0);
            repeat (int'(seed[2:0]) + 2) @(negedge clock);
            seed = lfsr(seed);
            host_u.xfer(8'h78, 1'b1, b);
            for (int i = 0; i < 3; i++) begin
                host_u.xfer(8'hff, 1'b0, b);
                w = {w[15:0], b};
            end
            chk("result", exp_q.pop_front(), w);
            wait_rdy(1'b1);
        end
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        nrst = 1'b0;
        res_valid = 1'b0;
        res_data = 24'h000000;
        seed = 32'h178d4253;
        num_errors = 0;
        num_checks = 0;
        for (int i = 0; i < 6; i++)
            cfg_m[i] = 0;
        // The link side resets through a synchroniser, so the link clock must run
        fork
            host_u.pulses(6);
            repeat (10) @(negedge clock);
        join
        nrst = 1'b1;
        chk("reset result_ready_n", 24'h1, {23'h0, result_ready_n});
        chk("reset dout_oe_n", 24'h1, {23'h0, dout_oe_n});
        check_cfg();
        // Two edges carry the release through the synchroniser; a third would count as a bit
        host_u.pulses(2);
        #20;
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            wr_cfg(i, (i == 1) ? {seed[7:1], 1'b0} : seed[7:0]);
        end
        check_cfg();
        // A byte that is no command must leave every setting alone
        host_u.xfer(8'h55, 1'b1, b);
        #80;
        check_cfg();
        repeat (2) begin
            fill(6, 1'b1);
            drain();
        end
        // With the hold bit set no new result may be offered to the host
        wr_cfg(1, 8'h01);
        check_cfg();
        fill(1, 1'b0);
        repeat (20) @(negedge clock);
        chk("held result_ready_n", 24'h1, {23'h0, result_ready_n});
        wr_cfg(1, 8'h00);
        drain();
        chk("idle dout_oe_n", 24'h0, {23'h0, dout_oe_n});
        host_u.xfer(8'h30, 1'b1, b);
        chk("released dout_oe_n", 24'h1, {23'h0, dout_oe_n});
        host_u.xfer(8'h5a, 1'b1, b);
        cfg_m[2] = 8'h5a;
        #80;
        check_cfg();
        finish_test();
    end

    initial begin
        #200000;
        num_errors++;
        $display("mismatch watchdog expected done seen hang");
        finish_test();
    end
endmodule
